// ### verilog/bracr_regs.sv
// Radio and advertising configuration register bank with an Avalon-MM slave.
// Assumes a single 50 MHz clock and a master that holds requests while waitrequest is high.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
module bracr_regs (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_b_in,
	// Avalon-MM slave
	input wire logic [31:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Diagnostic and radio settings
	output logic [31:0] profiling_word_out,
	output logic correlator_dc_path_enable_out,
	output logic [4:0] extended_radio_select_out,
	output logic [6:0] round_trip_latency_out,
	output logic [7:0] receive_powerup_time_out,
	output logic [3:0] transmit_powerdown_extension_out,
	output logic [7:0] transmit_powerup_time_out,
	output logic [2:0] advertising_channel_mask_out,
	// Advertising sequencing
	input wire logic adv_run_in,
	output logic adv_event_out,
	output logic [5:0] adv_channel_out,
	// Active scan counters
	input wire logic scan_load_in,
	input wire logic scan_step_in,
	output logic [8:0] scan_retreat_count_out,
	output logic scan_retreat_done_out,
	output logic [8:0] scan_ceiling_count_out
);
	typedef struct packed {
		logic [31:0] prof;
		logic [31:0] rctl0;
		logic [31:0] rctl1;
		logic [31:0] pwr;
		logic [31:0] chmap;
		logic [31:0] advertising_spacing;
		logic [31:0] scan;
		logic waitreq;
		logic [31:0] rdata;
		logic [5:0] div;
		logic tick;
		logic [1:0] chan_idx;
		logic adv_evt;
		logic [5:0] adv_chan;
		logic [8:0] scan_retreat_counter_init;
		logic scan_retreat_counter_init_done;
	} bracr_state_s;

	bracr_state_s st_r;
	bracr_state_s st_nxt;
	logic tmr_expire;

	// ==========================================================
	// Write merge honouring byte lanes and writable bits
	function automatic logic [31:0] bracr_merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be, input logic [31:0] wmask);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
		bracr_merge = (old & ~m) | (wd & m);
	endfunction

	// ==========================================================
	// Advertising interval timer
	// interval spacing
	bracr_us_timer #(
		.W(bracr_pkg::ADVERTISING_SPACING_W)
	) u_adv_timer (
		.clk_in(mclk_in),
		.rst_b_in(rst_b_in),
		.run_in(adv_run_in),
		.tick_in(st_r.tick),
		.period_in(st_r.advertising_spacing[bracr_pkg::ADVERTISING_SPACING_W-1:0]),
		.expire_out(tmr_expire)
	);

	// ==========================================================
	// Next state
	always_comb begin
		logic accept;
		logic [31:0] rd;
		logic found;
		logic [1:0] pick;
		logic [1:0] cand;
		accept = 1'b0;
		rd = '0;
		found = 1'b0;
		pick = st_r.chan_idx;
		cand = '0;
		st_nxt = st_r;

		// Microsecond enable divider
		// Free-running, so the first event after run waits for the next tick
		st_nxt.tick = 1'b0;
		if (st_r.div == 6'(bracr_pkg::US_CYCLES - 1)) begin
			st_nxt.div = '0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.div = st_r.div + 6'h01;
		end

		// Bus: one wait cycle, then the answer stands for one cycle
		if ((avs_read_in || avs_write_in) && st_r.waitreq) begin
			st_nxt.waitreq = 1'b0;
			case (avs_address_in)
				bracr_pkg::OFS_PROFILE: rd = st_r.prof;
				bracr_pkg::OFS_RCTL0: rd = st_r.rctl0;
				bracr_pkg::OFS_RCTL1: rd = st_r.rctl1;
				bracr_pkg::OFS_PWR: rd = st_r.pwr;
				bracr_pkg::OFS_CHMAP: rd = st_r.chmap;
				bracr_pkg::OFS_ADVERTISING_SPACING: rd = st_r.advertising_spacing;
				bracr_pkg::OFS_SCAN: rd = st_r.scan;
				bracr_pkg::OFS_STATUS: begin
					rd[bracr_pkg::ST_CHAN_LSB +: 6] = st_r.adv_chan;
					rd[bracr_pkg::ST_RUN_BIT] = adv_run_in;
					rd[bracr_pkg::ST_DONE_BIT] = st_r.scan_retreat_counter_init_done;
					rd[bracr_pkg::ST_SCAN_RETREAT_COUNTER_INIT_LSB +: 9] = st_r.scan_retreat_counter_init;
				end
				default: rd = '0;
			endcase
			st_nxt.rdata = avs_read_in ? rd : '0;
		end else if (!st_r.waitreq) begin
			st_nxt.waitreq = 1'b1;
			st_nxt.rdata = '0;
			accept = avs_write_in;
		end

		if (accept) begin
			// Status word is read only; a write to it falls to the default branch
			// reserved bits kept
			case (avs_address_in)
				bracr_pkg::OFS_PROFILE: begin
					st_nxt.prof = bracr_merge(st_r.prof, avs_writedata_in,
						avs_byteenable_in, bracr_pkg::WM_PROFILE);
				end
				bracr_pkg::OFS_RCTL0: st_nxt.rctl0 = bracr_merge(st_r.rctl0,
					avs_writedata_in, avs_byteenable_in, bracr_pkg::WM_RCTL0);
				bracr_pkg::OFS_RCTL1: st_nxt.rctl1 = bracr_merge(st_r.rctl1,
					avs_writedata_in, avs_byteenable_in, bracr_pkg::WM_RCTL1);
				bracr_pkg::OFS_PWR: st_nxt.pwr = bracr_merge(st_r.pwr,
					avs_writedata_in, avs_byteenable_in, bracr_pkg::WM_PWR);
				bracr_pkg::OFS_CHMAP: st_nxt.chmap = bracr_merge(st_r.chmap,
					avs_writedata_in, avs_byteenable_in, bracr_pkg::WM_CHMAP);
				bracr_pkg::OFS_ADVERTISING_SPACING: st_nxt.advertising_spacing = bracr_merge(st_r.advertising_spacing,
					avs_writedata_in, avs_byteenable_in, bracr_pkg::WM_ADVERTISING_SPACING);
				bracr_pkg::OFS_SCAN: st_nxt.scan = bracr_merge(st_r.scan,
					avs_writedata_in, avs_byteenable_in, bracr_pkg::WM_SCAN);
				default: ;
			endcase
		end

		st_nxt.adv_evt = 1'b0;
		for (int k = 1; k <= 3; k++) begin
			cand = 2'((int'(st_r.chan_idx) + k) % 3);
			if (!found && st_r.chmap[cand]) begin
				found = 1'b1;
				pick = cand;
			end
		end
		if (!adv_run_in) begin
			st_nxt.chan_idx = 2'h2;
		end else if (tmr_expire && found) begin
			st_nxt.chan_idx = pick;
			st_nxt.adv_evt = 1'b1;
			st_nxt.adv_chan = bracr_pkg::ADV_CHAN_BASE + 6'(pick);
		end

		if (scan_load_in) begin
			st_nxt.scan_retreat_counter_init = st_r.scan[bracr_pkg::SCAN_RETREAT_COUNTER_INIT_LSB +: bracr_pkg::SCAN_W];
		end else if (scan_step_in && st_r.scan_retreat_counter_init != '0) begin
			st_nxt.scan_retreat_counter_init = st_r.scan_retreat_counter_init - 9'h001;
		end
		st_nxt.scan_retreat_counter_init_done = (st_nxt.scan_retreat_counter_init == '0);
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_r <= '{prof: bracr_pkg::RST_PROFILE, rctl0: bracr_pkg::RST_RCTL0,
				rctl1: bracr_pkg::RST_RCTL1, pwr: bracr_pkg::RST_PWR,
				chmap: bracr_pkg::RST_CHMAP, advertising_spacing: bracr_pkg::RST_ADVERTISING_SPACING,
				scan: bracr_pkg::RST_SCAN, waitreq: 1'b1, rdata: 32'h00000000,
				div: 6'h00, tick: 1'b0, chan_idx: 2'h2, adv_evt: 1'b0,
				adv_chan: 6'h00, scan_retreat_counter_init: 9'h000, scan_retreat_counter_init_done: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs, each a slice of a flip-flop
	assign avs_readdata_out = st_r.rdata;
	assign avs_waitrequest_out = st_r.waitreq;
	assign profiling_word_out = st_r.prof;
	// passed through, software keeps it low
	assign correlator_dc_path_enable_out = st_r.rctl0[bracr_pkg::DC_PATH_BIT];
	assign extended_radio_select_out = st_r.rctl1[bracr_pkg::XRF_LSB +: bracr_pkg::XRF_W];
	assign round_trip_latency_out = st_r.pwr[bracr_pkg::RTRIP_LSB +: bracr_pkg::RTRIP_W];
	assign receive_powerup_time_out = st_r.pwr[bracr_pkg::RXPU_LSB +: bracr_pkg::RXPU_W];
	assign transmit_powerdown_extension_out =
		st_r.pwr[bracr_pkg::TXPD_LSB +: bracr_pkg::TXPD_W];
	assign transmit_powerup_time_out = st_r.pwr[bracr_pkg::TXPU_LSB +: bracr_pkg::TXPU_W];
	assign advertising_channel_mask_out = st_r.chmap[bracr_pkg::CHMAP_W-1:0];
	assign adv_event_out = st_r.adv_evt;
	assign adv_channel_out = st_r.adv_chan;
	assign scan_retreat_count_out = st_r.scan_retreat_counter_init;
	assign scan_retreat_done_out = st_r.scan_retreat_counter_init_done;
	assign scan_ceiling_count_out = st_r.scan[bracr_pkg::ULIM_LSB +: bracr_pkg::SCAN_W];

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_b_in);

	logic wr_accept;
	logic [19:0] gap_cnt_r;
	logic gap_clean_r;
	assign wr_accept = avs_write_in && !avs_waitrequest_out;

	// Cycles since the last event, trusted only while interval and run were steady
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			gap_cnt_r <= 20'h00000;
			gap_clean_r <= 1'b0;
		end else if (adv_event_out) begin
			gap_cnt_r <= 20'h00001;
			gap_clean_r <= 1'b1;
		end else begin
			gap_cnt_r <= gap_cnt_r + 20'h00001;
			// A mask change may skip expiries, so spacing is trusted again from the next event
			if (!adv_run_in || (wr_accept && (avs_address_in == bracr_pkg::OFS_ADVERTISING_SPACING
					|| avs_address_in == bracr_pkg::OFS_CHMAP))) begin
				gap_clean_r <= 1'b0;
			end
		end
	end

	chk_profile_mirror: assert property (
		wr_accept && avs_address_in == bracr_pkg::OFS_PROFILE && avs_byteenable_in == 4'hf
		|=> profiling_word_out == $past(avs_writedata_in))
		else $error("profiling word not mirrored");
	chk_rtrip_read: assert property (
		avs_read_in && !avs_waitrequest_out && avs_address_in == bracr_pkg::OFS_PWR
		|-> avs_readdata_out[30:24] == round_trip_latency_out)
		else $error("round-trip field mismatch");
	chk_rxpu_read: assert property (
		avs_read_in && !avs_waitrequest_out && avs_address_in == bracr_pkg::OFS_PWR
		|-> avs_readdata_out[23:16] == receive_powerup_time_out)
		else $error("receive power-up mismatch");
	chk_txpd_read: assert property (
		avs_read_in && !avs_waitrequest_out && avs_address_in == bracr_pkg::OFS_PWR
		|-> avs_readdata_out[11:8] == transmit_powerdown_extension_out)
		else $error("transmit power-down mismatch");
	chk_txpu_read: assert property (
		avs_read_in && !avs_waitrequest_out && avs_address_in == bracr_pkg::OFS_PWR
		|-> avs_readdata_out[7:0] == transmit_powerup_time_out)
		else $error("transmit power-up mismatch");
	chk_adv_channel: assert property (
		adv_event_out |-> adv_channel_out >= 6'h25 && adv_channel_out <= 6'h27
		&& ((($past(advertising_channel_mask_out) >> (adv_channel_out - 6'h25))
		& 3'h1) == 3'h1))
		else $error("advertised on a masked channel");
	chk_adv_spacing: assert property (
		adv_event_out && gap_clean_r && adv_run_in
		|-> gap_cnt_r == 20'(st_r.advertising_spacing[13:0] * bracr_pkg::US_CYCLES))
		else $error("advertising spacing wrong");
	chk_scan_retreat_counter_init_load: assert property (
		scan_load_in |=> scan_retreat_count_out == $past(st_r.scan[24:16]))
		else $error("back-off counter load wrong");
	chk_ceiling_write: assert property (
		wr_accept && avs_address_in == bracr_pkg::OFS_SCAN && avs_byteenable_in == 4'hf
		|=> scan_ceiling_count_out == $past(avs_writedata_in[8:0]))
		else $error("upper limit not taken");
	chk_reserved_bits: assert property (
		##1 ((st_r.rctl0 & ~bracr_pkg::WM_RCTL0) == (bracr_pkg::RST_RCTL0 & ~bracr_pkg::WM_RCTL0))
		&& ((st_r.pwr & ~bracr_pkg::WM_PWR) == 32'h00000000))
		else $error("reserved bits changed");
	chk_wait_single: assert property (
		!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low too long");
	// Bus answer: exactly one wait cycle per request
	chk_wait_answer: assert property (
		(avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("request not answered");
	chk_readdata_idle: assert property (
		avs_waitrequest_out |-> avs_readdata_out == 32'h00000000)
		else $error("read data outside answer");
	chk_scan_retreat_counter_init_step: assert property (
		scan_step_in && !scan_load_in && scan_retreat_count_out != 9'h000
		|=> scan_retreat_count_out == $past(scan_retreat_count_out) - 9'h001)
		else $error("back-off step wrong");

	cov_pwr_write: cover property (wr_accept && avs_address_in == bracr_pkg::OFS_PWR);
	cov_adv_event: cover property (adv_event_out ##[1:300] adv_event_out);
	cov_scan_retreat_counter_init_done: cover property (scan_step_in ##1 $rose(scan_retreat_done_out));
	cov_status_read: cover property (avs_read_in && !avs_waitrequest_out
		&& avs_address_in == bracr_pkg::OFS_STATUS);
	cov_mask_empty: cover property (tmr_expire && adv_run_in
		&& advertising_channel_mask_out == 3'h0);
endmodule

// ### verilog/bracr_pkg.sv
// Constants of the link-layer radio and advertising configuration registers.
// Assumes a 50 MHz core clock and 32-bit Avalon-MM byte addressing.
// Notes on behaviour
// - Profiling word mirrored onto diagnostic output
// - Round-trip latency taken from bits 30:24
// - Receive power-up time bits 23:16, reset 210
// - Transmit power-down extension bits 11:8, reset 3
// - Transmit power-up time bits 7:0, reset 210
// - Advertise on channel i+37 only if enabled
// - Space advertising packets by interval microseconds
// - Back-off counter loads from bits 24:16
// - Scan upper limit taken from bits 8:0
package bracr_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned US_NS = 1000;
	localparam int unsigned US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Register byte addresses
	localparam logic [31:0] OFS_PROFILE = 32'h40000064;
	localparam logic [31:0] OFS_RCTL0 = 32'h40000070;
	localparam logic [31:0] OFS_RCTL1 = 32'h40000074;
	localparam logic [31:0] OFS_PWR = 32'h40000080;
	localparam logic [31:0] OFS_CHMAP = 32'h40000090;
	localparam logic [31:0] OFS_ADVERTISING_SPACING = 32'h400000a0;
	localparam logic [31:0] OFS_SCAN = 32'h400000a4;
	localparam logic [31:0] OFS_STATUS = 32'h400000a8;

	// ==========================================================
	// Reset values and writable-bit masks
	localparam logic [31:0] RST_PROFILE = 32'h00000000;
	localparam logic [31:0] RST_RCTL0 = 32'h00002102;
	localparam logic [31:0] RST_RCTL1 = 32'h00000000;
	localparam logic [31:0] RST_PWR = 32'h00d203d2;
	localparam logic [31:0] RST_CHMAP = 32'h00000007;
	localparam logic [31:0] RST_ADVERTISING_SPACING = 32'h00000000;
	localparam logic [31:0] RST_SCAN = 32'h00000000;
	localparam logic [31:0] WM_PROFILE = 32'hffffffff;
	localparam logic [31:0] WM_RCTL0 = 32'h00400000;
	localparam logic [31:0] WM_RCTL1 = 32'h001f0000;
	localparam logic [31:0] WM_PWR = 32'h7fff0fff;
	localparam logic [31:0] WM_CHMAP = 32'h00000007;
	localparam logic [31:0] WM_ADVERTISING_SPACING = 32'h00003fff;
	localparam logic [31:0] WM_SCAN = 32'h01ff01ff;

	// ==========================================================
	// Field positions and widths
	localparam int DC_PATH_BIT = 22;
	localparam int XRF_LSB = 16;
	localparam int XRF_W = 5;
	localparam int RTRIP_LSB = 24;
	localparam int RTRIP_W = 7;
	localparam int RXPU_LSB = 16;
	localparam int RXPU_W = 8;
	localparam int TXPD_LSB = 8;
	localparam int TXPD_W = 4;
	localparam int TXPU_LSB = 0;
	localparam int TXPU_W = 8;
	localparam int CHMAP_W = 3;
	localparam int ADVERTISING_SPACING_W = 14;
	localparam int SCAN_RETREAT_COUNTER_INIT_LSB = 16;
	localparam int SCAN_W = 9;
	localparam int ULIM_LSB = 0;
	localparam int ST_CHAN_LSB = 0;
	localparam int ST_RUN_BIT = 8;
	localparam int ST_DONE_BIT = 9;
	localparam int ST_SCAN_RETREAT_COUNTER_INIT_LSB = 16;
	localparam logic [5:0] ADV_CHAN_BASE = 6'h25;

endpackage

// ### verilog/bracr_us_timer.sv
// Microsecond interval timer: one-cycle expiry pulse every period ticks.
// Assumes tick_in is a one-cycle enable once per microsecond.
`timescale 1ns/1ps
module bracr_us_timer #(
	parameter int W = 14
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Control
	input wire logic run_in,
	input wire logic tick_in,
	input wire logic [W-1:0] period_in,
	// Result
	output logic expire_out
);
	typedef struct packed {
		logic [W-1:0] count;
		logic expire;
	} bracr_tmr_s;

	bracr_tmr_s st_r;
	bracr_tmr_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.expire = 1'b0;
		// A zero period parks the timer rather than firing every tick
		if (!run_in || period_in == '0) begin
			st_nxt.count = '0;
		end else if (tick_in) begin
			if (st_r.count + W'(1) >= period_in) begin
				st_nxt.count = '0;
				st_nxt.expire = 1'b1;
			end else begin
				st_nxt.count = st_r.count + W'(1);
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign expire_out = st_r.expire;
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the radio and advertising configuration register bank.
// Assumes the bank answers each bus request after one wait cycle, as the hand-over says.
`timescale 1ns/1ps
module tb_top;
	// ==========================================================
	// Signals
	logic mclk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [31:0] avs_address_in = 32'h0;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [3:0] avs_byteenable_in = 4'hf;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	logic [31:0] profiling_word_out;
	logic correlator_dc_path_enable_out;
	logic [4:0] extended_radio_select_out;
	logic [6:0] round_trip_latency_out;
	logic [7:0] receive_powerup_time_out;
	logic [3:0] transmit_powerdown_extension_out;
	logic [7:0] transmit_powerup_time_out;
	logic [2:0] advertising_channel_mask_out;
	logic adv_run_in = 1'b0;
	logic adv_event_out;
	logic [5:0] adv_channel_out;
	logic scan_load_in = 1'b0;
	logic scan_step_in = 1'b0;
	logic [8:0] scan_retreat_count_out;
	logic scan_retreat_done_out;
	logic [8:0] scan_ceiling_count_out;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	logic [31:0] rdat;
	logic [31:0] adr_t [7] = '{32'h40000064, 32'h40000070, 32'h40000074, 32'h40000080,
		32'h40000090, 32'h400000a0, 32'h400000a4};
	logic [31:0] rst_t [7] = '{32'h0, 32'h00002102, 32'h0, 32'h00d203d2, 32'h7, 32'h0, 32'h0};
	logic [31:0] wm_t [7] = '{32'hffffffff, 32'h00400000, 32'h001f0000, 32'h7fff0fff,
		32'h7, 32'h3fff, 32'h01ff01ff};

	always #10 mclk_in = ~mclk_in;
	always @(posedge mclk_in) cyc <= cyc + 1;

	bracr_regs dut (.mclk_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
		.profiling_word_out, .correlator_dc_path_enable_out, .extended_radio_select_out,
		.round_trip_latency_out, .receive_powerup_time_out, .transmit_powerdown_extension_out,
		.transmit_powerup_time_out, .advertising_channel_mask_out, .adv_run_in, .adv_event_out,
		.adv_channel_out, .scan_load_in, .scan_step_in, .scan_retreat_count_out,
		.scan_retreat_done_out, .scan_ceiling_count_out);

	// ==========================================================
	// Shared tasks
	task results();
		if (bad_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			bad_count++;
		end
	endtask

	// Request held until waitrequest is seen low at a rising edge; data taken at that edge
	task bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge mclk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_byteenable_in <= be;
		avs_write_in <= wr;
		avs_read_in <= ~wr;
		do begin
			@(posedge mclk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 20);
		rdat = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		if (avs_waitrequest_out !== 1'b0) begin
			chk("waitrequest", 32'h0, 32'h1);
			results();
		end
	endtask

	task rd_chk(input string nm, input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hf);
		chk(nm, exp, rdat);
	endtask

	task wait_event(input int lim);
		int n;
		n = 0;
		do begin
			@(negedge mclk_in);
			n++;
		end while (adv_event_out !== 1'b1 && n < lim);
		if (n >= lim) begin
			chk("adv event", 32'h1, 32'h0);
			results();
		end
	endtask

	task step_scan(input logic ld, input logic [8:0] exp);
		@(posedge mclk_in);
		scan_load_in <= ld;
		scan_step_in <= ~ld;
		@(posedge mclk_in);
		scan_load_in <= 1'b0;
		scan_step_in <= 1'b0;
		@(negedge mclk_in);
		chk("retreat count", {23'h0, exp}, {23'h0, scan_retreat_count_out});
		chk("retreat done", {31'h0, exp == 9'h0}, {31'h0, scan_retreat_done_out});
	endtask

	// ==========================================================
	// Scenarios
	task scen_reset();
		for (int i = 0; i < 7; i++) begin
			rd_chk("reset value", adr_t[i], rst_t[i]);
		end
		chk("rx powerup", 32'hd2, {24'h0, receive_powerup_time_out});
		chk("tx powerdown", 32'h3, {28'h0, transmit_powerdown_extension_out});
		chk("tx powerup", 32'hd2, {24'h0, transmit_powerup_time_out});
		chk("channel mask", 32'h7, {29'h0, advertising_channel_mask_out});
	endtask

	// Each register gets the word, rctl0 with its DC path bit cleared and rctl1 with radio select 3; reserved bits must keep their reset level
	task scen_pattern(input logic [31:0] p);
		logic [31:0] w [7];
		for (int i = 0; i < 7; i++) begin
			w[i] = p;
		end
		w[1] = p & 32'hffbfffff;
		w[2] = (p & 32'hffe0ffff) | 32'h00030000;
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, adr_t[i], w[i], 4'hf);
		end
		for (int i = 0; i < 7; i++) begin
			rd_chk("readback", adr_t[i], (w[i] & wm_t[i]) | (rst_t[i] & ~wm_t[i]));
		end
		chk("profiling", p, profiling_word_out);
		chk("dc path", 32'h0, {31'h0, correlator_dc_path_enable_out});
		chk("radio select", 32'h3, {27'h0, extended_radio_select_out});
		chk("round trip", {25'h0, p[30:24]}, {25'h0, round_trip_latency_out});
		chk("rx powerup", {24'h0, p[23:16]}, {24'h0, receive_powerup_time_out});
		chk("tx powerdown", {28'h0, p[11:8]}, {28'h0, transmit_powerdown_extension_out});
		chk("tx powerup", {24'h0, p[7:0]}, {24'h0, transmit_powerup_time_out});
		chk("channel mask", {29'h0, p[2:0]}, {29'h0, advertising_channel_mask_out});
		chk("ceiling", {23'h0, p[8:0]}, {23'h0, scan_ceiling_count_out});
	endtask

	// Lanes 0 and 2 only; lanes 1 and 3 keep the earlier word
	task scen_bytes_unmapped();
		bus(1'b1, adr_t[0], 32'h11223344, 4'b0101);
		rd_chk("byte lanes", adr_t[0], 32'h1a220b44);
		bus(1'b1, 32'h40000068, 32'hffffffff, 4'hf);
		rd_chk("unmapped", 32'h40000068, 32'h0);
		rd_chk("profile kept", adr_t[0], 32'h1a220b44);
	endtask

	// Channels 37 and 39 enabled, 2 us interval: events 100 clocks apart
	task scen_adv();
		int t_last;
		int n_ev;
		t_last = 0;
		n_ev = 0;
		bus(1'b1, adr_t[4], 32'h5, 4'hf);
		bus(1'b1, adr_t[5], 32'h2, 4'hf);
		@(posedge mclk_in);
		adv_run_in <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			wait_event(160);
			if (k > 0) begin
				chk("event spacing", 32'd100, cyc - t_last);
			end
			t_last = cyc;
			@(negedge mclk_in);
			chk("adv channel", (k == 1) ? 32'd39 : 32'd37, {26'h0, adv_channel_out});
		end
		bus(1'b1, adr_t[4], 32'h0, 4'hf);
		repeat (300) begin
			@(negedge mclk_in);
			n_ev += (adv_event_out !== 1'b0);
		end
		chk("events with empty mask", 32'h0, n_ev);
		@(posedge mclk_in);
		adv_run_in <= 1'b0;
	endtask

	task scen_scan();
		bus(1'b1, adr_t[6], 32'h000301a5, 4'hf);
		@(negedge mclk_in);
		chk("ceiling", 32'h1a5, {23'h0, scan_ceiling_count_out});
		step_scan(1'b1, 9'h3);
		step_scan(1'b0, 9'h2);
		step_scan(1'b0, 9'h1);
		step_scan(1'b0, 9'h0);
		step_scan(1'b0, 9'h0);
		// Status: last channel 37, run low, done set, count zero
		rd_chk("status", 32'h400000a8, 32'h00000225);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		scen_reset();
		scen_pattern(32'hffffffff);
		scen_pattern(32'h0);
		scen_pattern(32'h1a030b15);
		scen_bytes_unmapped();
		scen_adv();
		scen_scan();
		results();
	end
endmodule
